// File: rtl/code_access_ctrl.v
// Purpose: holder code retry, enable and block state, file invalidation and auth gating
// Assumes: one request pulse at a time; state survives as long as power stays on
// Notes: non-volatile backing is modelled by preload ports sampled once just after reset release
// How it works
// RL1: change code only when the addressed code is enabled and not blocked
// RL2: change with correct old value reloads counter to three, stores new value
// RL3: change with wrong old value decrements counter, keeps stored value
// RL4: third wrong presentation blocks the code until a successful unblock
// RL5: disable only for primary code; refused when disabled or blocked
// RL6: correct disable reloads counter, marks disabled, files become always accessible
// RL7: wrong disable decrements counter, code stays enabled, third failure blocks
// RL8: enable only for primary code; refused when enabled or blocked
// RL9: correct enable reloads counter to three and enables the primary code
// RL10: wrong enable decrements, stays disabled; third failure blocks and enables
// RL11: blocked and disabled grants access; blocked and enabled denies it
// RL12: correct unblock stores new code, reloads ten and three, enables, grants
// RL13: unblock runs whether or not the holder code is blocked
// RL14: wrong unblock decrements its counter only; tenth failure blocks the unblock code
// RL15: invalidate sets current file flag only when its access condition holds
// RL16: invalidated file refuses all but select and rehabilitate unless allowed; invalidate on it is still accepted
// RL17: rehabilitate clears current file flag only when its access condition holds
// RL18: with barred dialling, identity and location files stay invalid until call control
// RL19: authenticate takes a challenge, runs algorithms with stored key, returns results
// RL20: authenticate needs the network directory current and primary code verified
// RL21: terminal passes the full cipher key unaltered to the air cipher
// RL22: later terminals never send the obsolete sleep command
// RL23: verify on usable code compares; match reloads three, miss decrements
// RL24: counters, codes and flags are kept so they survive between sessions; reset reinitialises counters and flags, codes reload via init ports
`timescale 1ns/100ps
`include "code_access_map.vh"

module code_access_ctrl #(
	parameter FILES = 16,
	parameter FILE_W = 4
)
(
	input wire core_clk_i,
	input wire rst_n_i,
	input wire req_i,
	input wire [3:0] op_i,
	input wire code_sel_i,
	input wire [`CODE_W-1:0] code_val_i,
	input wire [`CODE_W-1:0] new_code_i,
	input wire [FILE_W-1:0] cur_file_i,
	input wire file_cond_ok_i,
	input wire file_rw_when_invalid_i,
	input wire in_network_app_directory_i,
	input wire barred_dialling_mode_i,
	input wire call_control_supported_i,
	input wire [FILE_W-1:0] subscriber_identity_file_i,
	input wire [FILE_W-1:0] location_info_file_i,
	input wire [`CHAL_W-1:0] challenge_value_i,
	input wire [`SUBKEY_W-1:0] subscriber_key_i,
	input wire [`CODE_W-1:0] primary_init_i,
	input wire [`CODE_W-1:0] secondary_init_i,
	input wire [`CODE_W-1:0] unblock1_init_i,
	input wire [`CODE_W-1:0] unblock2_init_i,
	output reg done_o,
	output reg [2:0] result_o,
	output reg [`RESP_W-1:0] signed_response_o,
	output reg [`KEY_W-1:0] cipher_key_o,
	output reg primary_enabled_o,
	output reg [1:0] code_blocked_o,
	output reg [1:0] unblock_blocked_o,
	output reg [3:0] primary_tries_o,
	output reg [3:0] secondary_tries_o,
	output reg [1:0] access_granted_o,
	output reg primary_verified_o,
	output reg cur_file_invalid_o
);

// ----------------------------------------
// state
// ----------------------------------------
// held across sessions; a real card backs these with non-volatile cells
reg [`CODE_W-1:0] code_val [0:1]; // RL24
reg [`CODE_W-1:0] unb_val [0:1];
reg [3:0] tries [0:1];
reg [3:0] unb_tries [0:1];
reg [1:0] verified;
reg [FILES-1:0] invalid;
reg loaded;
reg busy;
reg [4:0] auth_cnt;
reg [`CHAL_W-1:0] mix;
reg [3:0] next_tries;
reg [3:0] next_unb;
reg [2:0] next_res;

wire sel = code_sel_i;
wire match = (code_val_i == code_val[sel]);
wire unb_match = (code_val_i == unb_val[sel]);
wire blocked = (tries[sel] == 4'h0);
wire unb_blk = (unb_tries[sel] == 4'h0);
wire usable = blocked ? 1'b0 : (sel ? 1'b1 : primary_enabled_o);
wire protect = (cur_file_i == subscriber_identity_file_i) ||
	(cur_file_i == location_info_file_i);
wire [3:0] cur_tries = tries[sel];
wire [3:0] cur_unb = unb_tries[sel];
wire primary_access = !primary_enabled_o || ((tries[0] != 4'h0) && verified[0]); // RL20
wire file_shut = invalid[cur_file_i] && !file_rw_when_invalid_i; // RL16

// ----------------------------------------
// helpers
// ----------------------------------------
function [3:0] dec;
	input [3:0] v;
	begin
		dec = (v == 4'h0) ? 4'h0 : v - 4'h1;
	end
endfunction

// toy one-round mixer standing in for the real algorithms
function [`CHAL_W-1:0] mix_step;
	input [`CHAL_W-1:0] s;
	input [`SUBKEY_W-1:0] k;
	begin
		mix_step = {s[`CHAL_W-2:0], s[`CHAL_W-1]} ^ k ^ {s[63:0], s[127:64]};
	end
endfunction

// ----------------------------------------
// request decode
// ----------------------------------------
// outcome of the request on the pins; applied only when it is taken
always @*
begin
	next_res = `RES_OK;
	next_tries = cur_tries;
	next_unb = cur_unb;
	case (op_i)
		`OP_VERIFY, `OP_CHANGE:
		begin
			if (!usable)
				next_res = blocked ? `RES_BLOCKED : `RES_REFUSED; // RL1
			else if (match)
				next_tries = `CODE_TRIES; // RL2 RL23
			else
			begin
				next_tries = dec(cur_tries); // RL3 RL4 RL23
				next_res = `RES_WRONG;
			end
		end
		`OP_DISABLE, `OP_ENABLE:
		begin
			if (sel || blocked || (primary_enabled_o == (op_i == `OP_ENABLE)))
				next_res = `RES_REFUSED; // RL5 RL8
			else if (match)
				next_tries = `CODE_TRIES; // RL6 RL9
			else
			begin
				next_tries = dec(cur_tries); // RL7 RL10
				next_res = `RES_WRONG;
			end
		end
		`OP_UNBLOCK:
		begin
			// no check of the holder code's blocked state
			if (unb_blk)
				next_res = `RES_BLOCKED; // RL13
			else if (unb_match)
			begin
				next_unb = `UNBLOCK_TRIES; // RL12
				next_tries = `CODE_TRIES; // RL12
			end
			else
			begin
				next_unb = dec(cur_unb); // RL14
				next_res = `RES_WRONG;
			end
		end
		`OP_INVALIDATE:
			if (!file_cond_ok_i)
				next_res = `RES_NO_ACCESS; // RL15
		`OP_REHAB:
		begin
			if (!file_cond_ok_i)
				next_res = `RES_NO_ACCESS; // RL17
			else if (barred_dialling_mode_i && !call_control_supported_i && protect)
				next_res = `RES_REFUSED; // RL18
		end
		`OP_READ, `OP_UPDATE:
		begin
			if (file_shut)
				next_res = `RES_REFUSED; // RL16
			else if (!file_cond_ok_i)
				next_res = `RES_NO_ACCESS;
		end
		`OP_SELECT:
			next_res = `RES_OK; // RL16
		`OP_AUTH:
		begin
			if (!in_network_app_directory_i || !primary_access)
				next_res = `RES_NO_ACCESS; // RL20
			else if (file_shut)
				next_res = `RES_REFUSED; // RL16
		end
		default:
			next_res = `RES_BAD_OP;
	endcase
end

// ----------------------------------------
// request handling
// ----------------------------------------
always @(posedge core_clk_i)
begin
	if (!rst_n_i)
	begin
		loaded <= 1'b0;
		busy <= 1'b0;
		auth_cnt <= 5'h00;
		mix <= {`CHAL_W{1'b0}};
		done_o <= 1'b0;
		result_o <= `RES_OK;
		signed_response_o <= {`RESP_W{1'b0}};
		cipher_key_o <= {`KEY_W{1'b0}};
		verified <= 2'h0;
		invalid <= {FILES{1'b0}};
		primary_enabled_o <= 1'b1;
		tries[0] <= `CODE_TRIES;
		tries[1] <= `CODE_TRIES;
		unb_tries[0] <= `UNBLOCK_TRIES;
		unb_tries[1] <= `UNBLOCK_TRIES;
		code_val[0] <= {`CODE_W{1'b0}};
		code_val[1] <= {`CODE_W{1'b0}};
		unb_val[0] <= {`CODE_W{1'b0}};
		unb_val[1] <= {`CODE_W{1'b0}};
	end
	else if (!loaded)
	begin
		// stored values caught after reset release
		loaded <= 1'b1;
		code_val[0] <= primary_init_i;
		code_val[1] <= secondary_init_i;
		unb_val[0] <= unblock1_init_i;
		unb_val[1] <= unblock2_init_i;
	end
	else if (busy)
	begin
		done_o <= 1'b0;
		mix <= mix_step(mix, subscriber_key_i); // RL19
		auth_cnt <= auth_cnt - 5'h01;
		if (auth_cnt == 5'h01)
		begin
			busy <= 1'b0;
			done_o <= 1'b1;
			result_o <= `RES_OK;
			signed_response_o <= mix[`RESP_W-1:0];
			cipher_key_o <= mix[127:64];
		end
	end
	else
	begin
		done_o <= req_i;
		if (req_i)
		begin
			tries[sel] <= next_tries;
			unb_tries[sel] <= next_unb;
			result_o <= next_res;
			case (op_i)
				`OP_VERIFY, `OP_CHANGE:
				begin
					if (next_res == `RES_OK)
					begin
						verified[sel] <= 1'b1; // RL23
						if (op_i == `OP_CHANGE)
							code_val[sel] <= new_code_i; // RL2
					end
					else if (next_res == `RES_WRONG)
						verified[sel] <= 1'b0; // RL3
				end
				`OP_DISABLE, `OP_ENABLE:
				begin
					if (next_res == `RES_OK)
						primary_enabled_o <= (op_i == `OP_ENABLE); // RL6 RL9
					// chosen: a block from enable also marks the code enabled
					else if (op_i == `OP_ENABLE && next_res == `RES_WRONG && next_tries == 4'h0)
						primary_enabled_o <= 1'b1; // RL10
					if (next_tries == 4'h0)
						verified[sel] <= 1'b0; // RL4 RL7
				end
				`OP_UNBLOCK:
					if (next_res == `RES_OK)
					begin
						code_val[sel] <= new_code_i; // RL12
						verified[sel] <= 1'b1;
						if (!sel)
							primary_enabled_o <= 1'b1;
					end
				`OP_INVALIDATE:
					if (next_res == `RES_OK)
						invalid[cur_file_i] <= 1'b1; // RL15
				`OP_REHAB:
					if (next_res == `RES_OK)
						invalid[cur_file_i] <= 1'b0; // RL17
				`OP_AUTH:
					if (next_res == `RES_OK)
					begin
						busy <= 1'b1; // RL19
						done_o <= 1'b0;
						auth_cnt <= `AUTH_CYCLES;
						mix <= challenge_value_i;
					end
				default:
					;
			endcase
		end
	end
end

// access: disabled primary grants always, blocked enabled never
function access_ok;
	input s;
	begin
		if (!s && !primary_enabled_o)
			access_ok = 1'b1; // RL6 RL11
		else
			access_ok = (tries[s] != 4'h0) && verified[s]; // RL4 RL11
	end
endfunction

// ----------------------------------------
// status outputs
// ----------------------------------------
always @(posedge core_clk_i)
begin
	if (!rst_n_i)
	begin
		code_blocked_o <= 2'h0;
		unblock_blocked_o <= 2'h0;
		primary_tries_o <= `CODE_TRIES;
		secondary_tries_o <= `CODE_TRIES;
		access_granted_o <= 2'h0;
		primary_verified_o <= 1'b0;
		cur_file_invalid_o <= 1'b0;
	end
	else
	begin
		code_blocked_o <= {tries[1] == 4'h0, tries[0] == 4'h0};
		unblock_blocked_o <= {unb_tries[1] == 4'h0, unb_tries[0] == 4'h0};
		primary_tries_o <= tries[0];
		secondary_tries_o <= tries[1];
		access_granted_o <= {access_ok(1'b1), access_ok(1'b0)};
		primary_verified_o <= verified[0];
		cur_file_invalid_o <= invalid[cur_file_i];
	end
end

endmodule

// File: shared/code_access_map.vh
// Purpose: constants for the holder code access control block
// Assumes: included by rtl/code_access_ctrl.v and by the checker, terminal model and bench
// Notes: codes and timing as used by the request decoder
`ifndef CODE_ACCESS_MAP_VH
`define CODE_ACCESS_MAP_VH

// request operation codes
`define OP_VERIFY 4'h1
`define OP_CHANGE 4'h2
`define OP_DISABLE 4'h3
`define OP_ENABLE 4'h4
`define OP_UNBLOCK 4'h5
`define OP_INVALIDATE 4'h6
`define OP_REHAB 4'h7
`define OP_AUTH 4'h8
`define OP_SELECT 4'h9
`define OP_READ 4'hA
`define OP_UPDATE 4'hB

// result codes
`define RES_OK 3'h0
`define RES_WRONG 3'h1
`define RES_REFUSED 3'h2
`define RES_BLOCKED 3'h3
`define RES_NO_ACCESS 3'h4
`define RES_BAD_OP 3'h5

// counter reload values
`define CODE_TRIES 4'h3
`define UNBLOCK_TRIES 4'hA

// widths
`define CODE_W 64
`define CHAL_W 128
`define RESP_W 32
`define KEY_W 64
`define SUBKEY_W 128

// cycles of the algorithm stand-in
`define AUTH_CYCLES 5'h10

`endif

// File: dv/code_access_monitor.sv
// Purpose: port checker for the holder code access block
// Assumes: one clock, synchronous active-low reset
// Notes: bound onto every code_access_ctrl instance
`timescale 1ns/100ps
`include "code_access_map.vh"
module code_access_monitor (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire req_i,
	input wire [3:0] op_i,
	input wire code_sel_i,
	input wire in_network_app_directory_i,
	input wire done_o,
	input wire [2:0] result_o,
	input wire primary_enabled_o,
	input wire [1:0] code_blocked_o,
	input wire [3:0] primary_tries_o,
	input wire [1:0] access_granted_o,
	input wire primary_verified_o,
	input wire cur_file_invalid_o
);
	// ----
	// properties
	// ----
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire take_auth = req_i && op_i == `OP_AUTH;
	wire auth_ok = in_network_app_directory_i && primary_verified_o && !cur_file_invalid_o;
	chk_verify_answer: assert property (req_i && op_i == `OP_VERIFY |=> done_o)
		else $error("verify not answered");
	chk_verify_reload: assert property (done_o && result_o == `RES_OK && $past(req_i)
		&& $past(op_i) == `OP_VERIFY && !$past(code_sel_i) |=> primary_tries_o == `CODE_TRIES)
		else $error("verify did not reload tries");
	chk_auth_latency: assert property (take_auth && auth_ok
		|=> !done_o [*8] ##1 !done_o [*8] ##1 done_o)
		else $error("auth latency wrong");
	chk_auth_gate: assert property (take_auth && !in_network_app_directory_i
		|-> ##[1:17] (done_o && result_o != `RES_OK))
		else $error("auth outside directory not refused");
	chk_zero_blocks: assert property (primary_tries_o == 4'h0 |-> code_blocked_o[0])
		else $error("empty counter not blocked");
	chk_disable_grant: assert property ($fell(primary_enabled_o) |-> ##[0:1] access_granted_o[0])
		else $error("disabled code without access");
	chk_blocked_deny: assert property ($rose(code_blocked_o[0]) && primary_enabled_o
		|-> ##[0:1] !access_granted_o[0])
		else $error("blocked enabled code grants access");
	chk_invalid_set: assert property (done_o && result_o == `RES_OK && $past(req_i)
		&& $past(op_i) == `OP_INVALIDATE |-> ##[0:1] cur_file_invalid_o)
		else $error("invalidate did not set flag");
	chk_disable_sel: assert property (req_i && op_i == `OP_DISABLE && code_sel_i
		|=> done_o && result_o != `RES_OK)
		else $error("disable on secondary accepted");
	cover property (take_auth ##[1:20] done_o);
	cover property ($rose(code_blocked_o[0]));
	cover property ($rose(cur_file_invalid_o));
endmodule
bind code_access_ctrl code_access_monitor mon_u (
	.core_clk_i(core_clk_i),
	.rst_n_i(rst_n_i),
	.req_i(req_i),
	.op_i(op_i),
	.code_sel_i(code_sel_i),
	.in_network_app_directory_i(in_network_app_directory_i),
	.done_o(done_o),
	.result_o(result_o),
	.primary_enabled_o(primary_enabled_o),
	.code_blocked_o(code_blocked_o),
	.primary_tries_o(primary_tries_o),
	.access_granted_o(access_granted_o),
	.primary_verified_o(primary_verified_o),
	.cur_file_invalid_o(cur_file_invalid_o)
);

// File: dv/terminal_model.sv
// Purpose: mobile terminal model issuing card requests
// Assumes: one request at a time, driven at the falling edge
// Notes: waits for done under a bounded count
`timescale 1ns/100ps
`include "code_access_map.vh"
module terminal_model (
	input wire core_clk_i,
	input wire done_i,
	input wire [63:0] cipher_key_i,
	output reg req_o,
	output reg [3:0] op_o,
	output reg sel_o,
	output reg [63:0] val_o,
	output reg [63:0] nval_o
);
	// ----
	// request driver
	// ----
	reg [63:0] air_key = 64'h0;
	integer lat = 0;
	initial
	begin
		req_o = 1'b0;
		op_o = 4'h0;
		sel_o = 1'b0;
		val_o = 64'h0;
		nval_o = 64'h0;
	end
	// only decoder opcodes; the obsolete sleep request is never sent
	task issue(input [3:0] o, input s, input [63:0] v, input [63:0] n);
	begin
		@(negedge core_clk_i);
		req_o = 1'b1;
		op_o = o;
		sel_o = s;
		val_o = v;
		nval_o = n;
		@(negedge core_clk_i);
		req_o = 1'b0;
		val_o = ~v;
		nval_o = ~n;
		lat = 0;
		while (!done_i && lat < 40)
		begin
			@(negedge core_clk_i);
			lat = lat + 1;
		end
		// full width, never trimmed before the air cipher
		if (o == `OP_AUTH)
			air_key = cipher_key_i;
		@(negedge core_clk_i);
	end
	endtask
endmodule

// File: dv/holder_code_access_control_tb.sv
// Purpose: directed bench for the holder code access block
// Assumes: stored codes preset through the init ports
// Notes: status outputs lag done by one cycle
`timescale 1ns/100ps
`include "code_access_map.vh"
module holder_code_access_control_tb;
	// ----
	// bench
	// ----
	localparam [63:0] B = 64'hBAD0;
	localparam [63:0] U = 64'h5555;
	localparam [63:0] C2 = 64'h2002;
	localparam [63:0] C3 = 64'h3003;
	localparam [63:0] Z = 64'h0;
	reg core_clk = 1'b0;
	reg rst_n = 1'b0;
	reg [3:0] file = 4'h3;
	reg cond = 1'b0;
	reg rwi = 1'b0;
	reg dir = 1'b0;
	reg bdm = 1'b0;
	reg ccs = 1'b0;
	reg [127:0] chal = 128'h0F1E2D3C;
	reg [63:0] pinit = 64'h1111;
	reg [63:0] uinit = U;
	integer err_count = 0;
	integer cmp_count = 0;
	integer cyc = 0;
	integer tn = 0;
	integer i;
	wire req, sel, done, pen, inv, pver;
	wire [3:0] op, ptry, stry;
	wire [63:0] val, nval, key;
	wire [31:0] signed_response;
	wire [2:0] res;
	wire [1:0] cblk, acc, ublk;
	always #5 core_clk = ~core_clk;
	terminal_model term_u (.core_clk_i(core_clk), .done_i(done), .cipher_key_i(key),
		.req_o(req), .op_o(op), .sel_o(sel), .val_o(val), .nval_o(nval));
	code_access_ctrl dut_u (.core_clk_i(core_clk), .rst_n_i(rst_n), .req_i(req), .op_i(op),
		.code_sel_i(sel), .code_val_i(val), .new_code_i(nval), .cur_file_i(file),
		.file_cond_ok_i(cond), .file_rw_when_invalid_i(rwi), .in_network_app_directory_i(dir),
		.barred_dialling_mode_i(bdm), .call_control_supported_i(ccs),
		.subscriber_identity_file_i(4'h1), .location_info_file_i(4'h2),
		.challenge_value_i(chal), .subscriber_key_i(128'h7777), .primary_init_i(pinit),
		.secondary_init_i(64'h2222), .unblock1_init_i(uinit), .unblock2_init_i(64'h6666),
		.done_o(done), .result_o(res), .signed_response_o(signed_response), .cipher_key_o(key),
		.primary_enabled_o(pen), .code_blocked_o(cblk), .unblock_blocked_o(ublk),
		.primary_tries_o(ptry), .secondary_tries_o(stry), .access_granted_o(acc),
		.primary_verified_o(pver), .cur_file_invalid_o(inv));
	task chk(input [63:0] seen, input [63:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			err_count = err_count + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task q(input [3:0] o, input s, input [63:0] v, input [63:0] n);
		term_u.issue(o, s, v, n);
	endtask
	task endt;
	begin
		tn = tn + 1;
		$display("test %0d finished", tn);
	end
	endtask
	task give_verdict;
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	// ceiling well above the roughly 190 cycles the tests need
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_count = err_count + 1;
			give_verdict;
		end
	end
	initial
	begin
		repeat (10) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge core_clk);
		chk({pen, ptry}, 5'h13);
		for (i = 2; i >= 0; i = i - 1)
		begin
			q(`OP_VERIFY, 1'b0, B, Z);
			chk(ptry, i);
		end
		chk({cblk[0], acc[0]}, 2'b10);
		q(`OP_VERIFY, 1'b0, pinit, Z);
		chk(res, `RES_BLOCKED);
		endt;
		q(`OP_UNBLOCK, 1'b0, B, C2);
		chk({res, cblk[0]}, {`RES_WRONG, 1'b1});
		q(`OP_UNBLOCK, 1'b0, U, C2);
		chk({ptry, cblk[0], acc[0]}, {4'h3, 2'b01});
		chk(pver, 1'b1);
		q(`OP_UNBLOCK, 1'b0, U, C2);
		chk(res, `RES_OK);
		endt;
		q(`OP_CHANGE, 1'b0, B, C3);
		chk({res, ptry}, {`RES_WRONG, 4'h2});
		q(`OP_VERIFY, 1'b0, C2, Z);
		chk({res, term_u.lat[3:0]}, {`RES_OK, 4'h0});
		q(`OP_CHANGE, 1'b0, C2, C3);
		q(`OP_VERIFY, 1'b0, C3, Z);
		chk({res, ptry}, {`RES_OK, 4'h3});
		endt;
		q(`OP_VERIFY, 1'b1, B, Z);
		chk(stry, 4'h2);
		q(`OP_VERIFY, 1'b1, 64'h2222, Z);
		chk(stry, 4'h3);
		for (i = 9; i >= 0; i = i - 1)
		begin
			chk(ublk, 2'b00);
			q(`OP_UNBLOCK, 1'b1, B, C2);
		end
		chk(ublk, 2'b10);
		q(`OP_UNBLOCK, 1'b1, 64'h6666, C2);
		chk({res, stry}, {`RES_BLOCKED, 4'h3});
		endt;
		q(`OP_DISABLE, 1'b1, C3, Z);
		chk(res, `RES_REFUSED);
		q(`OP_DISABLE, 1'b0, B, Z);
		chk({pen, ptry}, 5'h12);
		q(`OP_DISABLE, 1'b0, C3, Z);
		chk({pen, acc[0], ptry}, 6'h13);
		q(`OP_DISABLE, 1'b0, C3, Z);
		chk(res, `RES_REFUSED);
		q(`OP_CHANGE, 1'b0, C3, B);
		chk(res, `RES_REFUSED);
		q(`OP_ENABLE, 1'b1, C3, Z);
		chk(res, `RES_REFUSED);
		q(`OP_ENABLE, 1'b0, B, Z);
		chk({pen, ptry}, 5'h02);
		q(`OP_ENABLE, 1'b0, C3, Z);
		chk({pen, ptry}, 5'h13);
		q(`OP_ENABLE, 1'b0, C3, Z);
		chk(res, `RES_REFUSED);
		q(`OP_DISABLE, 1'b0, C3, Z);
		repeat (3) q(`OP_ENABLE, 1'b0, B, Z);
		chk({pen, cblk[0], acc[0]}, 3'b110);
		q(`OP_UNBLOCK, 1'b0, U, C3);
		endt;
		q(`OP_INVALIDATE, 1'b0, Z, Z);
		chk(inv, 1'b0);
		cond = 1'b1;
		q(`OP_INVALIDATE, 1'b0, Z, Z);
		chk(inv, 1'b1);
		q(`OP_READ, 1'b0, Z, Z);
		chk(res == `RES_OK, 1'b0);
		q(`OP_SELECT, 1'b0, Z, Z);
		chk(res, `RES_OK);
		rwi = 1'b1;
		q(`OP_UPDATE, 1'b0, Z, Z);
		chk(res, `RES_OK);
		cond = 1'b0;
		q(`OP_REHAB, 1'b0, Z, Z);
		chk(inv, 1'b1);
		cond = 1'b1;
		q(`OP_REHAB, 1'b0, Z, Z);
		chk(inv, 1'b0);
		endt;
		bdm = 1'b1;
		for (i = 1; i < 3; i = i + 1)
		begin
			file = i[3:0];
			ccs = 1'b0;
			q(`OP_INVALIDATE, 1'b0, Z, Z);
			q(`OP_REHAB, 1'b0, Z, Z);
			chk(inv, 1'b1);
			ccs = 1'b1;
			q(`OP_REHAB, 1'b0, Z, Z);
			chk(inv, 1'b0);
		end
		endt;
		file = 4'h0;
		q(`OP_VERIFY, 1'b0, C3, Z);
		chk(pver, 1'b1);
		q(`OP_AUTH, 1'b0, Z, Z);
		chk(res == `RES_OK, 1'b0);
		chk(signed_response, 32'h0);
		chk(key, 64'h0);
		dir = 1'b1;
		q(`OP_AUTH, 1'b0, Z, Z);
		chk({res, term_u.lat[4:0]}, {`RES_OK, 5'h10});
		chk(signed_response == 32'h0, 1'b0);
		chk(term_u.air_key, key);
		endt;
		give_verdict;
	end
endmodule
